// ===== rtl/dac_pwr_params.svh
`ifndef DAC_PWR_PARAMS_SVH
`define DAC_PWR_PARAMS_SVH

// Register offsets on the serial configuration port
`define PMC_OFFSET        5'h00
`define SLEEP_OFFSET      5'h01
`define STATUS_OFFSET     5'h02

// Field positions
`define PMC_PD_BIT        4
`define PMC_AUTOPD_BIT    3
`define SLEEP_MAIN_BIT    0
`define SLEEP_AUX_BIT     1
`define STAT_ENGINE_BIT   0
`define STAT_FLUSH_BIT    1
`define STAT_TXEN_BIT     2
`define STAT_PD_BIT       3

// Serial instruction layout
`define INSTR_READ_BIT    7
`define INSTR_ADDR_MSB    4

// Reset values
`define PMC_RESET         8'h00
`define SLEEP_RESET       8'h00

// Timing counts: flush in reference clock cycles, frame length in sclk bits
`define FLUSH_REF_CYCLES  16
`define SPI_BITS          16

`endif

// ===== rtl/dac_pwr_pkg.sv
package dac_pwr_pkg;

   typedef enum logic [1:0] {
      ENG_RUN   = 2'b00,
      ENG_FLUSH = 2'b01,
      ENG_DOWN  = 2'b11
   } engine_state_t;

   typedef struct packed {
      logic main_dac_on;
      logic ref_on;
      logic analog_on;
      logic aux_dac_on;
      logic engine_on;
   } power_state_t;

   typedef struct packed {
      logic       wr;
      logic [4:0] addr;
      logic [7:0] data;
   } reg_write_t;

endpackage

// ===== rtl/dac_serial_port.sv
`timescale 1ns/1ps
`include "dac_pwr_params.svh"

module dac_serial_port (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Pins
   input  wire logic                  sclk,
   input  wire logic                  csb,
   input  wire logic                  sdio_in,
   output logic                       sdio_out,
   output logic                       sdio_oe,
   // Register side
   output logic [4:0]                 rd_addr,
   input  wire logic [7:0]            rd_data,
   output dac_pwr_pkg::reg_write_t    wr
);

   logic [2:0] sclk_s;
   logic [1:0] csb_s;
   logic [1:0] sdio_s;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [6:0] shin;
   logic [6:0] next_shin;
   logic [7:0] instr;
   logic [7:0] next_instr;
   logic [7:0] shout;
   logic [7:0] next_shout;
   logic       loaded;
   logic       next_loaded;
   dac_pwr_pkg::reg_write_t next_wr;
   logic       rise;
   logic       fall;
   logic       rd_mode;

   // Third sclk stage only feeds the edge detect, never the first stage
   assign rise    = sclk_s[1] & ~sclk_s[2];
   assign fall    = ~sclk_s[1] & sclk_s[2];
   assign rd_mode = instr[`INSTR_READ_BIT] & (cnt >= 5'd8);
   assign rd_addr = instr[`INSTR_ADDR_MSB:0];
   assign sdio_out = shout[7];
   assign sdio_oe  = rd_mode & loaded & ~csb_s[1];

   always_comb begin
      next_cnt    = cnt;
      next_shin   = shin;
      next_instr  = instr;
      next_shout  = shout;
      next_loaded = loaded;
      next_wr     = '0;
      if (csb_s[1]) begin
         next_cnt    = 5'd0;
         next_loaded = 1'b0;
         next_instr  = 8'h00;
      end else begin
         if (rise && cnt < 5'(`SPI_BITS)) begin
            next_shin = {shin[5:0], sdio_s[1]};
            next_cnt  = cnt + 5'd1;
            if (cnt == 5'd7) begin
               next_instr = {shin, sdio_s[1]};
            end
            if (cnt == 5'd15 && !instr[`INSTR_READ_BIT]) begin
               next_wr.wr   = 1'b1;
               next_wr.addr = instr[`INSTR_ADDR_MSB:0];
               next_wr.data = {shin, sdio_s[1]};
            end
         end
         if (fall && rd_mode) begin
            if (!loaded) begin
               next_shout  = rd_data;
               next_loaded = 1'b1;
            end else begin
               next_shout = {shout[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s <= 3'h0;
         csb_s  <= 2'h3;
         sdio_s <= 2'h0;
         cnt    <= 5'h00;
         shin   <= 7'h00;
         instr  <= 8'h00;
         shout  <= 8'h00;
         loaded <= 1'b0;
         wr     <= '0;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk};
         csb_s  <= {csb_s[0], csb};
         sdio_s <= {sdio_s[0], sdio_in};
         cnt    <= next_cnt;
         shin   <= next_shin;
         instr  <= next_instr;
         shout  <= next_shout;
         loaded <= next_loaded;
         wr     <= next_wr;
      end
   end

endmodule

// ===== rtl/dac_power_down_control.sv
`timescale 1ns/1ps
`include "dac_pwr_params.svh"

module dac_power_down_control #(
   parameter int DATA_W       = 16,
   parameter int FLUSH_CYCLES = `FLUSH_REF_CYCLES
) (
   // Reference clock and reset
   input  wire logic                     CLK,
   input  wire logic                     RST_N,
   // Serial configuration port
   input  wire logic                     SCLK,
   input  wire logic                     CSB,
   input  wire logic                     SDIO_IN,
   output logic                          SDIO_OUT,
   output logic                          SDIO_OE,
   // Transmit enable pin
   input  wire logic                     TRANSMIT_ENABLE_PIN,
   // Data path
   input  wire logic [DATA_W-1:0]        DATA_IN,
   output logic [DATA_W-1:0]             DATA_OUT,
   // Power controls
   output dac_pwr_pkg::power_state_t     POWER
);

   logic [7:0]                pmc;
   logic [7:0]                next_pmc;
   logic [7:0]                sleep;
   logic [7:0]                next_sleep;
   logic [1:0]                txen_s;
   logic [15:0]               flush_cnt;
   logic [15:0]               next_flush_cnt;
   dac_pwr_pkg::engine_state_t state;
   dac_pwr_pkg::engine_state_t next_state;
   dac_pwr_pkg::power_state_t  next_power;
   dac_pwr_pkg::reg_write_t    wr;
   logic [DATA_W-1:0]         next_data;
   logic [4:0]                rd_addr;
   logic [7:0]                rd_data;
   logic [7:0]                status;
   logic                      pd;
   logic                      auto_pd;
   logic                      txen;
   logic [1:0]                next_txen_s;
   logic                      wr_pmc;
   logic                      wr_sleep;
   logic                      wake;
   logic                      flush_done;

   assign pd      = pmc[`PMC_PD_BIT];
   assign auto_pd = pmc[`PMC_AUTOPD_BIT];
   assign txen    = txen_s[1];

   // Only a complete write frame raises these strobes
   assign wr_pmc   = wr.wr && (wr.addr == `PMC_OFFSET);
   assign wr_sleep = wr.wr && (wr.addr == `SLEEP_OFFSET);

   // Clearing the auto bit wakes the engine as surely as the pin
   assign wake       = txen || !auto_pd;
   assign flush_done = (flush_cnt == 16'h0000);

   // Port runs on the reference clock alone, untouched by any power state
   dac_serial_port u_port (
      .clk      (CLK),
      .rst_n    (RST_N),
      .sclk     (SCLK),
      .csb      (CSB),
      .sdio_in  (SDIO_IN),
      .sdio_out (SDIO_OUT),
      .sdio_oe  (SDIO_OE),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data),
      .wr       (wr)
   );

   // Status is a live view; writes aimed at it are dropped
   always_comb begin
      status = 8'h00;
      status[`STAT_ENGINE_BIT] = POWER.engine_on;
      status[`STAT_FLUSH_BIT]  = (state == dac_pwr_pkg::ENG_FLUSH);
      status[`STAT_TXEN_BIT]   = txen;
      status[`STAT_PD_BIT]     = pd;
   end

   // Unmapped addresses read as zero
   always_comb begin
      case (rd_addr)
         `PMC_OFFSET:    rd_data = pmc;
         `SLEEP_OFFSET:  rd_data = sleep;
         `STATUS_OFFSET: rd_data = status;
         default:        rd_data = 8'h00;
      endcase
   end

   // Register writes
   always_comb begin
      next_pmc   = pmc;
      next_sleep = sleep;
      if (wr_pmc) begin
         next_pmc = wr.data;
      end
      // Sleep keeps only its two defined bits
      if (wr_sleep) begin
         next_sleep = wr.data & 8'h03;
      end
   end

   // Digital engine sequencer
   always_comb begin
      next_state     = state;
      next_flush_cnt = flush_cnt;
      case (state)
         dac_pwr_pkg::ENG_RUN: begin
            if (!wake) begin
               next_state     = dac_pwr_pkg::ENG_FLUSH;
               // Loaded one short: the entering edge is the first flush cycle
               next_flush_cnt = 16'(FLUSH_CYCLES - 1);
            end
         end
         dac_pwr_pkg::ENG_FLUSH: begin
            // Enable returning mid-flush aborts it; host should wait it out
            if (wake) begin
               next_state = dac_pwr_pkg::ENG_RUN;
            end else if (flush_done) begin
               next_state = dac_pwr_pkg::ENG_DOWN;
            end else begin
               next_flush_cnt = flush_cnt - 16'h0001;
            end
         end
         dac_pwr_pkg::ENG_DOWN: begin
            if (wake) begin
               next_state = dac_pwr_pkg::ENG_RUN;
            end
         end
         default: begin
            next_state = dac_pwr_pkg::ENG_RUN;
         end
      endcase
   end

   // Power outputs; auto power-down touches only the engine
   always_comb begin
      // Full power-down overrides sleep and the sequencer
      next_power = '0;
      if (!pd) begin
         next_power.ref_on      = 1'b1;
         next_power.analog_on   = 1'b1;
         next_power.main_dac_on = !sleep[`SLEEP_MAIN_BIT];
         next_power.aux_dac_on  = !sleep[`SLEEP_AUX_BIT];
         next_power.engine_on   = (next_state != dac_pwr_pkg::ENG_DOWN);
      end
   end

   // Zero samples whenever enable is low, flushing the pipeline
   always_comb begin
      if (txen && next_power.engine_on) begin
         next_data = DATA_IN;
      end else begin
         next_data = '0;
      end
   end

   // Two stages before anything reads the pin
   always_comb begin
      next_txen_s = {txen_s[0], TRANSMIT_ENABLE_PIN};
   end

   // Configuration registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pmc   <= `PMC_RESET;
         sleep <= `SLEEP_RESET;
      end else begin
         pmc   <= next_pmc;
         sleep <= next_sleep;
      end
   end

   // Reset low: data path zero-fills until the pin is seen
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         txen_s <= 2'h0;
      end else begin
         txen_s <= next_txen_s;
      end
   end

   // Engine sequencer
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state     <= dac_pwr_pkg::ENG_RUN;
         flush_cnt <= 16'h0000;
      end else begin
         state     <= next_state;
         flush_cnt <= next_flush_cnt;
      end
   end

   // Outputs reset to all off, as a powered-down part
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         POWER    <= '0;
         DATA_OUT <= '0;
      end else begin
         POWER    <= next_power;
         DATA_OUT <= next_data;
      end
   end

endmodule

// ===== sim/dac_power_down_control_chk.sv
`timescale 1ns/1ps
module dac_power_down_control_chk #(
   parameter int DATA_W       = 16,
   parameter int FLUSH_CYCLES = 16
) (
   // Clock and reset
   input wire logic                      CLK,
   input wire logic                      RST_N,
   // Pins
   input wire logic                      CSB,
   input wire logic                      SDIO_OE,
   input wire logic                      TRANSMIT_ENABLE_PIN,
   input wire logic [DATA_W-1:0]         DATA_IN,
   input wire logic [DATA_W-1:0]         DATA_OUT,
   input wire dac_pwr_pkg::power_state_t POWER
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_low; !TRANSMIT_ENABLE_PIN [*4]; endsequence
   sequence s_high; TRANSMIT_ENABLE_PIN [*4]; endsequence
   property p_pd; !POWER.ref_on |-> POWER == 5'h00; endproperty
   a_pd: assert property (p_pd) else $error("domain left on");
   property p_spare;
      $fell(POWER.engine_on) && POWER.ref_on |->
         $stable({POWER.main_dac_on, POWER.ref_on, POWER.analog_on, POWER.aux_dac_on});
   endproperty
   a_spare: assert property (p_spare) else $error("converter dropped with engine");
   property p_zero; s_low |=> DATA_OUT == '0; endproperty
   a_zero: assert property (p_zero) else $error("data not zero");
   property p_fall;
      // Pin low since before the sync stages and the whole flush
      $fell(POWER.engine_on) && POWER.ref_on |->
         $past(TRANSMIT_ENABLE_PIN, FLUSH_CYCLES + 3) == 1'b0;
   endproperty
   a_fall: assert property (p_fall) else $error("early engine off");
   property p_wake; s_high ##0 POWER.ref_on |=> POWER.engine_on || !POWER.ref_on; endproperty
   a_wake: assert property (p_wake) else $error("engine asleep");
   property p_pass;
      s_high ##0 POWER.engine_on ##1 (TRANSMIT_ENABLE_PIN && POWER.engine_on)
         |-> DATA_OUT == $past(DATA_IN);
   endproperty
   a_pass: assert property (p_pass) else $error("data not passed");
   property p_oe_idle; CSB [*4] |-> !SDIO_OE; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("drive while idle");
   property p_oe_rise; $rose(SDIO_OE) |-> $past(CSB, 3) == 1'b0; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("drive unselected");
endmodule
bind dac_power_down_control dac_power_down_control_chk #(
   .DATA_W(DATA_W), .FLUSH_CYCLES(FLUSH_CYCLES)
) dac_power_down_control_chk_inst (
   .CLK(CLK), .RST_N(RST_N), .CSB(CSB), .SDIO_OE(SDIO_OE),
   .TRANSMIT_ENABLE_PIN(TRANSMIT_ENABLE_PIN), .DATA_IN(DATA_IN),
   .DATA_OUT(DATA_OUT), .POWER(POWER)
);

// ===== sim/dac_host_model.sv
`timescale 1ns/1ps
module dac_host_model (
   // Clock
   input  wire logic clk,
   // Serial port and enable
   output logic      sclk,
   output logic      csb,
   output logic      sdo,
   input  wire logic sdio,
   output logic      txen
);
   initial begin
      sclk = 0;
      csb = 1;
      sdo = 0;
      txen = 1;
   end
   task automatic half();
      repeat (6) @(negedge clk);
   endtask
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      logic [15:0] f;
      f = {rd, 2'b00, a, d};
      q = 8'h00;
      csb = 0;
      for (int i = 15; i >= 0; i--) begin
         // Released line toggles so a stale level cannot pass
         sdo = (rd && i < 8) ? ~sdo : f[i];
         half();
         if (i < 8) q[i] = sdio;
         sclk = 1;
         half();
         sclk = 0;
      end
      csb = 1;
      sdo = ~sdo;
      half();
   endtask
   // Level holds until the next call; the task returns at once and does not wait out the flush
   task automatic set_txen(input logic v);
      txen = v;
   endtask
endmodule

// ===== sim/dac_power_down_control_tb_top.sv
`timescale 1ns/1ps
module dac_power_down_control_tb_top;
   typedef struct packed {
      logic [7:0]                pmc;
      logic [7:0]                slp;
      logic                      txen;
      dac_pwr_pkg::power_state_t pwr;
   } row_t;
   logic                      clk = 0;
   logic                      rst_n = 0;
   logic                      sclk, csb, sdo, txen, sdio_out, sdio_oe;
   wire logic                 sdio_in;
   logic [15:0]               data_in = 16'h0001;
   logic [15:0]               data_out;
   logic [7:0]                q;
   dac_pwr_pkg::power_state_t power;
   int                        n_fail = 0;
   int                        tests_run = 0;
   row_t                      rows [7] = '{
      '{8'h00, 8'h00, 1'b1, 5'h1F},
      '{8'h00, 8'h01, 1'b1, 5'h0F},
      '{8'h00, 8'h02, 1'b1, 5'h1D},
      '{8'h10, 8'h00, 1'b1, 5'h00},
      '{8'h00, 8'h00, 1'b0, 5'h1F},
      '{8'h08, 8'h00, 1'b0, 5'h1E},
      '{8'h08, 8'h00, 1'b1, 5'h1F}};
   always #20 clk = ~clk;
   always @(negedge clk) data_in <= data_in + 16'h1357;
   assign sdio_in = sdio_oe ? sdio_out : sdo;
   dac_power_down_control #(.DATA_W(16), .FLUSH_CYCLES(2)) dac_power_down_control_inst (
      .CLK(clk), .RST_N(rst_n), .SCLK(sclk), .CSB(csb), .SDIO_IN(sdio_in),
      .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .TRANSMIT_ENABLE_PIN(txen),
      .DATA_IN(data_in), .DATA_OUT(data_out), .POWER(power));
   dac_host_model dac_host_model_inst (
      .clk(clk), .sclk(sclk), .csb(csb), .sdo(sdo), .sdio(sdio_in), .txen(txen));
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("Error at %0t ns: %s", $time, m);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      close_out();
   end
   initial begin
      repeat (5) @(negedge clk);
      chk(power === 5'h00, "power in reset");
      @(negedge clk);
      rst_n = 1;
      repeat (2) @(negedge clk);
      chk(power === 5'h1F, "power after reset");
      foreach (rows[i]) begin
         dac_host_model_inst.xfer(1'b0, 5'h00, rows[i].pmc, q);
         dac_host_model_inst.xfer(1'b0, 5'h01, rows[i].slp, q);
         dac_host_model_inst.set_txen(rows[i].txen);
         repeat (40) @(negedge clk);
         chk(power === rows[i].pwr, "power state");
         chk(data_out === ((rows[i].txen && rows[i].pwr.engine_on) ? data_in : 16'h0000),
             "data path");
         dac_host_model_inst.xfer(1'b1, 5'h00, 8'h00, q);
         chk(q === rows[i].pmc, "readback");
      end
      dac_host_model_inst.set_txen(1'b0);
      repeat (3) @(negedge clk);
      chk(power.engine_on === 1'b1, "engine off before flush");
      repeat (20) @(negedge clk);
      chk(power.engine_on === 1'b0, "engine still on");
      dac_host_model_inst.xfer(1'b1, 5'h02, 8'h00, q);
      chk(q === 8'h00, "status while down");
      dac_host_model_inst.set_txen(1'b1);
      repeat (10) @(negedge clk);
      chk(power === 5'h1F, "engine not woken");
      dac_host_model_inst.xfer(1'b1, 5'h02, 8'h00, q);
      chk(q === 8'h05, "status while running");
      dac_host_model_inst.set_txen(1'b0);
      @(negedge clk);
      dac_host_model_inst.set_txen(1'b1);
      repeat (8) begin
         @(negedge clk);
         chk(power.engine_on === 1'b1, "short low pulse powered down");
      end
      dac_host_model_inst.xfer(1'b0, 5'h01, 8'hFF, q);
      dac_host_model_inst.xfer(1'b1, 5'h01, 8'h00, q);
      chk(q === 8'h03, "sleep bits kept");
      chk(power === 5'h0D, "both converters asleep");
      dac_host_model_inst.xfer(1'b0, 5'h1F, 8'hFF, q);
      dac_host_model_inst.xfer(1'b1, 5'h1F, 8'h00, q);
      chk(q === 8'h00, "unmapped read");
      close_out();
   end
endmodule
